// ---- logic/jti_evt_fifo.sv ----
// Purpose: Flip-flop FIFO carrying sampled test clock edge events to the controller.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Depth must be a power of two; full and empty come from a pointer pair with a wrap bit.
`timescale 1ns/100ps
`default_nettype none

module jti_evt_fifo #(
    parameter int W = 3,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    // Full when the pointers differ only in the wrap bit; empty when they are equal.
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_ptr_r[AW-1:0]];

    // Write side.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
        end else if (in_valid && !full) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
            wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
        end
    end

    // Read side.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr_r <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
        end
    end

endmodule // jti_evt_fifo

`default_nettype wire

// ---- logic/jti_tap.sv ----
// Purpose: Boundary-scan test access port: controller, instruction register, decoder and the
//          bypass, identification and boundary data paths, all oversampled on SYS_CLK.
// Assumes: Test pins are asynchronous to SYS_CLK and the test clock is well below SYS_CLK/4.
// Notes: Test clock edges become events in a FIFO; TAP_HOLD stalls the controller.
`timescale 1ns/100ps
`default_nettype none

module jti_tap #(
    parameter int BSR_W = jti_pkg::BSR_W_DEF,
    parameter int EVT_DEPTH = jti_pkg::EVT_DEPTH_DEF,
    parameter logic [jti_pkg::ID_W-1:0] ID_VALUE = jti_pkg::ID_VALUE_DEF
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    input wire logic CHIP_RST_N,
    input wire logic TAP_HOLD,
    input wire logic [BSR_W-1:0] PIN_IN,
    input wire logic [BSR_W-1:0] CORE_OUT,
    input wire logic [BSR_W-1:0] CORE_OE,
    output logic TDO,
    output logic TDO_OE,
    output logic [BSR_W-1:0] PIN_OUT,
    output logic [BSR_W-1:0] PIN_OE,
    output logic EVT_OVERRUN
);

    // Pin synchronisers: the first stage feeds only the second.
    logic tck_s1_r, tck_s2_r, tck_d3_r;
    logic tms_s1_r, tms_s2_r;
    logic tdi_s1_r, tdi_s2_r;
    logic trst_n_s1_r, trst_n_s2_r;
    logic crst_n_s1_r, crst_n_s2_r, crst_n_d3_r;
    logic [BSR_W-1:0] pin_s1_r, pin_s2_r;

    // Event path.
    jti_pkg::jti_evt_t evt_in;
    jti_pkg::jti_evt_t evt_out;
    logic evt_push, evt_in_ready, evt_valid, evt_pop;

    // Controller and registers.
    jti_pkg::jti_state_t state_r, state_nxt;
    logic [jti_pkg::IR_W-1:0] ir_shift_r;
    logic [jti_pkg::IR_W-1:0] ir_r;
    logic byp_r;
    logic [jti_pkg::ID_W-1:0] id_r;
    logic [BSR_W-1:0] bsr_r;
    logic [BSR_W-1:0] bsr_upd_r;
    logic float_r;
    logic tdo_r, tdo_oe_r, overrun_r;
    logic [BSR_W-1:0] pin_out_r, pin_oe_r;

    // Decoded selections.
    logic sel_bsr, sel_id, drive_from_bsr, float_now;
    logic do_rise, do_fall;

    // Two flip-flops on every asynchronous pin; pull-ups on mode select and serial input and
    // the pull-down on test reset sit in the pads.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            tck_s1_r <= 1'b0;
            tck_s2_r <= 1'b0;
            tck_d3_r <= 1'b0;
            tms_s1_r <= 1'b1;
            tms_s2_r <= 1'b1;
            tdi_s1_r <= 1'b1;
            tdi_s2_r <= 1'b1;
            trst_n_s1_r <= 1'b0;
            trst_n_s2_r <= 1'b0;
            crst_n_s1_r <= 1'b0;
            crst_n_s2_r <= 1'b0;
            crst_n_d3_r <= 1'b0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            tck_s1_r <= TCK;
            tck_s2_r <= tck_s1_r;
            tck_d3_r <= tck_s2_r;
            tms_s1_r <= TMS;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= TDI;
            tdi_s2_r <= tdi_s1_r;
            trst_n_s1_r <= TRST_N;
            trst_n_s2_r <= trst_n_s1_r;
            crst_n_s1_r <= CHIP_RST_N;
            crst_n_s2_r <= crst_n_s1_r;
            crst_n_d3_r <= crst_n_s2_r;
            pin_s1_r <= PIN_IN;
            pin_s2_r <= pin_s1_r;
        end
    end

    // An edge of the synchronised test clock becomes one event; mode select and serial input
    // are taken with it, so only rising events carry meaningful inputs. No edge, no event,
    // which is why a stopped test clock leaves the controller and scan registers untouched.
    assign evt_push = (tck_s2_r != tck_d3_r) && trst_n_s2_r;
    assign evt_in.rise = tck_s2_r;
    assign evt_in.tms = tms_s2_r;
    assign evt_in.tdi = tdi_s2_r;

    // Event buffer; the controller may be stalled by TAP_HOLD and catches up afterwards.
    jti_evt_fifo #(
        .W($bits(jti_pkg::jti_evt_t)),
        .DEPTH(EVT_DEPTH)
    ) u_evt_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST || !trst_n_s2_r),
        .in_valid(evt_push),
        .in_ready(evt_in_ready),
        .in_data(evt_in),
        .out_valid(evt_valid),
        .out_ready(evt_pop),
        .out_data(evt_out)
    );

    assign evt_pop = evt_valid && !TAP_HOLD && trst_n_s2_r;
    assign do_rise = evt_pop && evt_out.rise;
    assign do_fall = evt_pop && !evt_out.rise;

    // A lost edge cannot be recovered, so it is flagged until test reset clears it.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !trst_n_s2_r) begin
            overrun_r <= 1'b0;
        end else if (evt_push && !evt_in_ready) begin
            overrun_r <= 1'b1;
        end
    end

    // Instruction decode. Extest and sample use the boundary register, idcode the
    // identification register; everything else, debug, private and unused codes included,
    // falls back to the bypass cell.
    always_comb begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        drive_from_bsr = 1'b0;
        unique case (ir_r)
            jti_pkg::OP_EXTEST: begin
                sel_bsr = 1'b1;
                drive_from_bsr = 1'b1;
            end
            jti_pkg::OP_SAMPLE: begin
                sel_bsr = 1'b1;
            end
            jti_pkg::OP_CLAMP: begin
                drive_from_bsr = 1'b1;
            end
            jti_pkg::OP_IDCODE: begin
                sel_id = 1'b1;
            end
            default: begin
                sel_bsr = 1'b0;
            end
        endcase
    end

    // Outputs float only while highz is the active instruction and the request was seen.
    assign float_now = float_r && (ir_r == jti_pkg::OP_HIGHZ);

    // Controller next state, advanced by mode select on rising edges.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            jti_pkg::ST_TLR: state_nxt = evt_out.tms ? jti_pkg::ST_TLR : jti_pkg::ST_RTI;
            jti_pkg::ST_RTI: state_nxt = evt_out.tms ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
            jti_pkg::ST_SEL_DR: state_nxt = evt_out.tms ? jti_pkg::ST_SEL_IR : jti_pkg::ST_CAP_DR;
            jti_pkg::ST_CAP_DR: state_nxt = evt_out.tms ? jti_pkg::ST_EX1_DR : jti_pkg::ST_SH_DR;
            jti_pkg::ST_SH_DR: state_nxt = evt_out.tms ? jti_pkg::ST_EX1_DR : jti_pkg::ST_SH_DR;
            jti_pkg::ST_EX1_DR: state_nxt = evt_out.tms ? jti_pkg::ST_UPD_DR : jti_pkg::ST_PAU_DR;
            jti_pkg::ST_PAU_DR: state_nxt = evt_out.tms ? jti_pkg::ST_EX2_DR : jti_pkg::ST_PAU_DR;
            jti_pkg::ST_EX2_DR: state_nxt = evt_out.tms ? jti_pkg::ST_UPD_DR : jti_pkg::ST_SH_DR;
            jti_pkg::ST_UPD_DR: state_nxt = evt_out.tms ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
            jti_pkg::ST_SEL_IR: state_nxt = evt_out.tms ? jti_pkg::ST_TLR : jti_pkg::ST_CAP_IR;
            jti_pkg::ST_CAP_IR: state_nxt = evt_out.tms ? jti_pkg::ST_EX1_IR : jti_pkg::ST_SH_IR;
            jti_pkg::ST_SH_IR: state_nxt = evt_out.tms ? jti_pkg::ST_EX1_IR : jti_pkg::ST_SH_IR;
            jti_pkg::ST_EX1_IR: state_nxt = evt_out.tms ? jti_pkg::ST_UPD_IR : jti_pkg::ST_PAU_IR;
            jti_pkg::ST_PAU_IR: state_nxt = evt_out.tms ? jti_pkg::ST_EX2_IR : jti_pkg::ST_PAU_IR;
            jti_pkg::ST_EX2_IR: state_nxt = evt_out.tms ? jti_pkg::ST_UPD_IR : jti_pkg::ST_SH_IR;
            jti_pkg::ST_UPD_IR: state_nxt = evt_out.tms ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
            default: state_nxt = jti_pkg::ST_TLR;
        endcase
    end

    // Controller state. Test reset low acts on the synchronised level alone, with no test
    // clock edge needed.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !trst_n_s2_r) begin
            state_r <= jti_pkg::ST_TLR;
        end else if (do_rise) begin
            state_r <= state_nxt;
        end
    end

    // Instruction shift stage: capture the fixed pattern, then shift with input at the MSB.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !trst_n_s2_r) begin
            ir_shift_r <= jti_pkg::OP_IDCODE;
        end else if (do_rise) begin
            if (state_r == jti_pkg::ST_CAP_IR) begin
                ir_shift_r <= jti_pkg::IR_CAPTURE_VAL;
            end else if (state_r == jti_pkg::ST_SH_IR) begin
                ir_shift_r <= {evt_out.tdi, ir_shift_r[jti_pkg::IR_W-1:1]};
            end
        end
    end

    // Latched instruction: changes only at Update_IR or in Test_Logic_Reset, on a falling edge.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !trst_n_s2_r) begin
            ir_r <= jti_pkg::OP_IDCODE;
        end else if (do_fall) begin
            if (state_r == jti_pkg::ST_UPD_IR) begin
                ir_r <= ir_shift_r;
            end else if (state_r == jti_pkg::ST_TLR) begin
                ir_r <= jti_pkg::OP_IDCODE;
            end
        end
    end

    // Bypass cell: captures zero and shifts whenever bypass is the selected path.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            byp_r <= jti_pkg::BYP_CAPTURE_VAL;
        end else if (do_rise && !sel_bsr && !sel_id) begin
            if (state_r == jti_pkg::ST_CAP_DR) begin
                byp_r <= jti_pkg::BYP_CAPTURE_VAL;
            end else if (state_r == jti_pkg::ST_SH_DR) begin
                byp_r <= evt_out.tdi;
            end
        end
    end

    // Identification register: parallel load of the fixed value, then a shift that takes the
    // serial input in at the MSB; shifted-in bits stay until the next capture reloads the value.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            id_r <= ID_VALUE;
        end else if (do_rise && sel_id) begin
            if (state_r == jti_pkg::ST_CAP_DR) begin
                id_r <= ID_VALUE;
            end else if (state_r == jti_pkg::ST_SH_DR) begin
                id_r <= {evt_out.tdi, id_r[jti_pkg::ID_W-1:1]};
            end
        end
    end

    // Boundary shift cells: capture pin values, shift toward the serial output.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            bsr_r <= '0;
        end else if (do_rise && sel_bsr) begin
            if (state_r == jti_pkg::ST_CAP_DR) begin
                bsr_r <= pin_s2_r;
            end else if (state_r == jti_pkg::ST_SH_DR) begin
                bsr_r <= {evt_out.tdi, bsr_r[BSR_W-1:1]};
            end
        end
    end

    // Boundary slave cells: copied on the falling edge in Update_DR. Under clamp nothing
    // writes them, so the clamped values hold for as long as clamp stays active.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            bsr_upd_r <= '0;
        end else if (do_fall && sel_bsr && state_r == jti_pkg::ST_UPD_DR) begin
            bsr_upd_r <= bsr_r;
        end
    end

    // Float request: the highz instruction is looked at when chip reset is released.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            float_r <= 1'b0;
        end else if (crst_n_s2_r && !crst_n_d3_r) begin
            float_r <= (ir_r == jti_pkg::OP_HIGHZ);
        end
    end

    // Serial output: updated on falling edges only, driven only in the two shift states so
    // that several devices can share the line.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !trst_n_s2_r) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (do_fall) begin
            tdo_oe_r <= (state_r == jti_pkg::ST_SH_IR) || (state_r == jti_pkg::ST_SH_DR);
            if (state_r == jti_pkg::ST_SH_IR) begin
                tdo_r <= ir_shift_r[0];
            end else if (sel_id) begin
                tdo_r <= id_r[0];
            end else if (sel_bsr) begin
                tdo_r <= bsr_r[0];
            end else begin
                tdo_r <= byp_r;
            end
        end
    end

    // Pin drivers. The core's own values pass through unless extest or clamp take the pins or highz floats the enables;
    // the extra register stage costs one system clock of latency on functional outputs.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else begin
            pin_out_r <= drive_from_bsr ? bsr_upd_r : CORE_OUT;
            if (float_now) begin
                pin_oe_r <= '0;
            end else if (drive_from_bsr) begin
                pin_oe_r <= '1;
            end else begin
                pin_oe_r <= CORE_OE;
            end
        end
    end

    assign TDO = tdo_r;
    assign TDO_OE = tdo_oe_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE = pin_oe_r;
    assign EVT_OVERRUN = overrun_r;

endmodule // jti_tap

`default_nettype wire

// ---- shared/jti_pkg.sv ----
// Purpose: Shared constants and types for the boundary-scan test access port logic.
// Assumes: Test clock, mode select, serial input and test reset arrive as pins and are
//          oversampled by the system clock.
// Notes: Instruction codes, capture patterns and controller state codes live here only.
`default_nettype none

package jti_pkg;

    // Instruction register width and the fixed pattern loaded in Capture_IR.
    localparam int IR_W = 5;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 5'h01;

    // Public instruction codes.
    localparam logic [IR_W-1:0] OP_EXTEST = 5'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE = 5'h01;
    localparam logic [IR_W-1:0] OP_CLAMP = 5'h04;
    localparam logic [IR_W-1:0] OP_HIGHZ = 5'h08;
    localparam logic [IR_W-1:0] OP_IDCODE = 5'h1E;
    localparam logic [IR_W-1:0] OP_BYPASS = 5'h1F;

    // Debug access instruction codes; their private registers are not part of this block.
    localparam logic [IR_W-1:0] OP_DBG_RX = 5'h02;
    localparam logic [IR_W-1:0] OP_LOAD_CACHE = 5'h07;
    localparam logic [IR_W-1:0] OP_DBG_CTRL = 5'h09;
    localparam logic [IR_W-1:0] OP_DBG_TX = 5'h10;

    // Identification register width and the value the bypass cell captures.
    localparam int ID_W = 32;
    localparam logic BYP_CAPTURE_VAL = 1'b0;

    // Default identification value; the value is arbitrary, bit 0 set as the standard expects.
    localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h0A5C_0001;

    // Default number of boundary cells and event buffer depth.
    localparam int BSR_W_DEF = 16;
    localparam int EVT_DEPTH_DEF = 16;

    // One sampled test clock edge with the serial inputs seen at that instant.
    typedef struct packed {
        logic rise;
        logic tms;
        logic tdi;
    } jti_evt_t;

    // Sixteen controller states, one-hot.
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } jti_state_t;

endpackage

`default_nettype wire

// ---- test/jti_master.sv ----
// Purpose: Behavioural test master driving the scan pins.
// Assumes: Calls start on a falling system clock; the test clock rests low between calls.
// Notes: A bit is 400 ns; serial out is read 100 ns after the rise, while it stands.
`timescale 1ns/100ps
`default_nettype none

module jti_master (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Undriven serial inputs rest high; test reset starts asserted.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
    end

    // Test reset is held high whenever the port is to operate.
    task automatic set_trst(input logic v);
        trst_n = v;
    endtask

    // One period; inputs change while the clock is low and hold across the rise.
    task automatic bit_io(input logic m, input logic d, output logic o, output logic oe);
        tms = m;
        tdi = d;
        #200;
        tck = 1'b1;
        #100;
        o = tdo_oe ? tdo : !tdo;
        oe = tdo_oe;
        #100;
        tck = 1'b0;
    endtask

    // Whole scan from idle back to idle; ir picks the instruction path.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_all);
        logic o;
        logic oe;
        dout = 32'h0000_0000;
        oe_all = 1'b1;
        bit_io(1'b1, 1'b1, o, oe);
        if (ir)
            bit_io(1'b1, 1'b1, o, oe);
        bit_io(1'b0, 1'b1, o, oe);
        bit_io(1'b0, 1'b1, o, oe);
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1, din[i], o, oe);
            dout[i] = o;
            oe_all = oe_all & oe;
        end
        bit_io(1'b1, 1'b1, o, oe);
        bit_io(1'b0, 1'b1, o, oe);
    endtask

    // Five high mode-select edges reach Test_Logic_Reset from anywhere, then idle.
    task automatic tms_reset();
        logic o;
        logic oe;
        for (int i = 0; i < 5; i++)
            bit_io(1'b1, 1'b1, o, oe);
        bit_io(1'b0, 1'b1, o, oe);
    endtask
endmodule // jti_master

`default_nettype wire

// ---- test/jti_tap_asserts.sv ----
// Purpose: Port-level assertions for the test access port.
// Assumes: The test clock stays low and high for four system clocks or more.
// Notes: Bound to jti_tap at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module jti_tap_asserts #(
    parameter int BSR_W = 16
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic TCK,
    input wire logic TRST_N,
    input wire logic TAP_HOLD,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic [BSR_W-1:0] PIN_OE,
    input wire logic [BSR_W-1:0] PIN_OUT,
    input wire logic EVT_OVERRUN
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    // Idle counter; it waits long enough for queued edge events to drain first.
    logic tck_q_r;
    logic [5:0] quiet_r;
    always_ff @(posedge SYS_CLK) begin
        tck_q_r <= TCK;
        if (SYS_RST || TCK != tck_q_r || TAP_HOLD || !TRST_N)
            quiet_r <= 6'h00;
        else if (quiet_r != 6'h3F)
            quiet_r <= quiet_r + 6'h01;
    end

    property p_tdo_fall;
        TDO_OE && $past(TDO_OE) && $changed(TDO) |-> !$past(TCK, 2);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off a falling edge");
    property p_oe_rise;
        $rose(TDO_OE) |-> !$past(TCK, 2) && TRST_N;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("output enable rose badly");
    property p_oe_fall;
        $fell(TDO_OE) |-> !$past(TCK, 2) || !TRST_N;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("output enable fell badly");
    property p_trst;
        !TRST_N [*4] |=> !TDO_OE;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset left serial out driven");
    property p_rst_vals;
        $fell(SYS_RST) |-> !TDO_OE && PIN_OE == '0 && PIN_OUT == '0 && !EVT_OVERRUN;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_quiet;
        quiet_r >= 6'h28 |-> $stable(TDO) && $stable(TDO_OE) && $stable(PIN_OUT);
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs moved with test clock stopped");
    property p_ovr_keep;
        EVT_OVERRUN && TRST_N && $past(TRST_N) && $past(TRST_N, 2) && $past(TRST_N, 3)
            |=> EVT_OVERRUN;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun flag not sticky");
    property p_ovr_cause;
        $rose(EVT_OVERRUN) |-> $past(TAP_HOLD) || $past(TAP_HOLD, 2);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without a stall");
endmodule // jti_tap_asserts

bind jti_tap jti_tap_asserts #(.BSR_W(BSR_W)) u_chk (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .TCK(TCK), .TRST_N(TRST_N), .TAP_HOLD(TAP_HOLD),
    .TDO(TDO), .TDO_OE(TDO_OE), .PIN_OE(PIN_OE), .PIN_OUT(PIN_OUT), .EVT_OVERRUN(EVT_OVERRUN)
);

`default_nettype wire

// ---- test/jti_tap_bench.sv ----
// Purpose: Self-checking bench for the test access port.
// Assumes: Pin and core values are driven from the bench and changed by the boundary and highz tasks; scan pins come from the master model.
// Notes: One task per scenario, each judging its own results.
`timescale 1ns/100ps
`default_nettype none

module jti_tap_bench;
    localparam logic [31:0] ID = jti_pkg::ID_VALUE_DEF;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_rst_n = 1'b1;
    logic tap_hold = 1'b0;
    logic [15:0] pin_in = 16'h5A3C;
    logic [15:0] core_out = 16'h1234, core_oe = 16'h00FF;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, evt_overrun, o, oe, oe_all;
    logic [15:0] pin_out, pin_oe;
    logic [31:0] dout;
    int fail_count = 0;
    int cmp_count = 0;

    // System clock, 50 ns period.
    always #25 sys_clk = ~sys_clk;

    jti_tap u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TRST_N(trst_n), .CHIP_RST_N(chip_rst_n), .TAP_HOLD(tap_hold), .PIN_IN(pin_in),
        .CORE_OUT(core_out), .CORE_OE(core_oe), .TDO(tdo), .TDO_OE(tdo_oe),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .EVT_OVERRUN(evt_overrun));
    jti_master u_mst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe(tdo_oe));

    // Compare and count; X never passes for a match.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_idcode();
        u_mst.scan(1'b0, 32, 32'hFFFF_FFFF, dout, oe_all);
        chk("id capture", ID, dout);
        chk("tdo driven", 1, oe_all);
        chk("tdo idle", 0, tdo_oe);
        u_mst.scan(1'b0, 32, 32'h0000_0000, dout, oe_all);
        chk("id unchanged", ID, dout);
    endtask

    task automatic t_ir_bypass();
        u_mst.scan(1'b1, 5, 32'h0000_001F, dout, oe_all);
        chk("ir capture", 32'(jti_pkg::IR_CAPTURE_VAL), dout);
        u_mst.scan(1'b0, 8, 32'h0000_00A5, dout, oe_all);
        chk("bypass path", 32'h0000_004A, dout);
    endtask

    // Debug, private, unused, clamp and highz codes all give a one-bit path.
    task automatic t_codes();
        logic [4:0] codes [16] = '{5'h02, 5'h07, 5'h09, 5'h10, 5'h03, 5'h05, 5'h0A, 5'h0B,
            5'h0C, 5'h0D, 5'h06, 5'h0E, 5'h11, 5'h1D, 5'h04, 5'h08};
        foreach (codes[i]) begin
            u_mst.scan(1'b1, 5, 32'(codes[i]), dout, oe_all);
            u_mst.scan(1'b0, 2, 32'h0000_0003, dout, oe_all);
            chk("one-bit path", 32'h0000_0002, dout);
        end
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_IDCODE), dout, oe_all);
        u_mst.scan(1'b0, 32, 32'h0000_0000, dout, oe_all);
        chk("idcode path", ID, dout);
    endtask

    task automatic t_boundary();
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_SAMPLE), dout, oe_all);
        u_mst.scan(1'b0, 16, 32'h0000_C3A5, dout, oe_all);
        chk("sample capture", 32'h0000_5A3C, dout);
        chk("sample pins", 32'h0000_1234, pin_out);
        chk("sample oe", 32'h0000_00FF, pin_oe);
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_EXTEST), dout, oe_all);
        chk("extest pins", 32'h0000_C3A5, pin_out);
        chk("extest oe", 32'h0000_FFFF, pin_oe);
        pin_in = 16'h0F0F;
        u_mst.scan(1'b0, 16, 32'h0000_9696, dout, oe_all);
        chk("extest capture", 32'h0000_0F0F, dout);
        chk("extest update", 32'h0000_9696, pin_out);
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_CLAMP), dout, oe_all);
        chk("clamp pins", 32'h0000_9696, pin_out);
    endtask

    task automatic t_highz();
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_HIGHZ), dout, oe_all);
        chip_rst_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        chip_rst_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk("highz float", 0, pin_oe);
        u_mst.scan(1'b1, 5, 32'(jti_pkg::OP_BYPASS), dout, oe_all);
        chk("bypass pins", 32'h0000_00FF, pin_oe);
        core_out = 16'hA55A;
        repeat (4) @(negedge sys_clk);
        chk("bypass core", 32'h0000_A55A, pin_out);
    endtask

    // Test reset mid-shift, then mode-select reset from Pause_DR.
    task automatic t_resets();
        u_mst.bit_io(1'b1, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        chk("shift oe", 1, tdo_oe);
        u_mst.set_trst(1'b0);
        repeat (10) @(negedge sys_clk);
        chk("trst oe", 0, tdo_oe);
        u_mst.set_trst(1'b1);
        repeat (5) @(negedge sys_clk);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.scan(1'b0, 32, 32'h0000_0000, dout, oe_all);
        chk("trst idcode", ID, dout);
        u_mst.scan(1'b1, 5, 32'h0000_001F, dout, oe_all);
        u_mst.bit_io(1'b1, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.bit_io(1'b1, 1'b1, o, oe);
        u_mst.bit_io(1'b0, 1'b1, o, oe);
        u_mst.tms_reset();
        u_mst.scan(1'b0, 32, 32'h0000_0000, dout, oe_all);
        chk("tms idcode", ID, dout);
    endtask

    // Stalled controller: the event queue fills until it refuses, then drains.
    task automatic t_fifo();
        int n;
        tap_hold = 1'b1;
        for (n = 0; n < 7; n++)
            u_mst.bit_io(1'b1, 1'b1, o, oe);
        chk("no overrun", 0, evt_overrun);
        for (n = 0; n < 6 && evt_overrun !== 1'b1; n++)
            u_mst.bit_io(1'b1, 1'b1, o, oe);
        chk("overrun", 1, evt_overrun);
        tap_hold = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk("overrun sticky", 1, evt_overrun);
        u_mst.set_trst(1'b0);
        repeat (10) @(negedge sys_clk);
        chk("overrun clear", 0, evt_overrun);
        u_mst.set_trst(1'b1);
        repeat (5) @(negedge sys_clk);
        u_mst.tms_reset();
        u_mst.scan(1'b0, 32, 32'h0000_0000, dout, oe_all);
        chk("alive after drain", ID, dout);
    endtask

    // Main sequence; inputs move on falling system clock edges.
    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        u_mst.set_trst(1'b1);
        repeat (5) @(negedge sys_clk);
        chk("reset oe", 0, tdo_oe);
        u_mst.tms_reset();
        t_idcode();
        t_ir_bypass();
        t_codes();
        t_boundary();
        t_highz();
        t_resets();
        t_fifo();
        wrap_up();
    end

    // Cuts a hang short; counts as a mismatch.
    initial begin
        #5000000;
        fail_count++;
        $display("[FAIL] run time expected finish seen hang");
        wrap_up();
    end
endmodule // jti_tap_bench

`default_nettype wire
